// *** mps_host_model.sv ***
`timescale 1ns/1ns
module mps_host_model
  import mps_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [7:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [7:0] wdat_o,
  output logic sel_o
);
  initial begin
    {cyc_o, stb_o, we_o, sel_o} = 4'h0;
    {adr_o, wdat_o} = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o} <= {2'h3, w, 1'b1};
    adr_o <= a;
    wdat_o <= d;
    // Ack and read data are taken as sampled at this same rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    if (n >= 50) tb_monitor_powerup_sequencer.hang();
    q = rdat_i;
    {cyc_o, stb_o, we_o, sel_o} <= 4'h0;
    // Released lines show garbage, not the last value
    adr_o <= ~a;
    wdat_o <= ~d;
    @(negedge clk_i);
  endtask : xfer
  task automatic configure(input logic [7:0] lim, input logic [7:0] duty);
    logic [7:0] q;
    xfer(1'b1, MPS_CFG3_ADDR, MPS_CFG3_RESET, q);
    xfer(1'b1, MPS_BATT_LIMIT_ADDR, lim, q);
    xfer(1'b1, MPS_FAN_DUTY_ADDR, duty, q);
    xfer(1'b1, MPS_CFG1_ADDR, MPS_CFG1_RESET | 8'h20, q);
  endtask : configure
endmodule : mps_host_model

// *** mps_nocomm_timer.sv ***
`timescale 1ns/1ns
module mps_nocomm_timer
  import mps_pkg::*;
#(
  parameter int unsigned COUNT = 32'(MPS_NOCOMM_CYCLES)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rail_on_i,
  input wire logic bus_seen_i,
  output logic expired_o
);
  logic [31:0] count;
  wire clear_count = rst_i || !rail_on_i || bus_seen_i;
  wire at_end = (count == COUNT - 32'd1);

  always_ff @(posedge clk_i) begin
    if (clear_count) begin
      count <= '0;
    end else if (!at_end) begin
      count <= count + 32'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !rail_on_i || bus_seen_i) begin
      expired_o <= 1'b0;
    end else if (at_end) begin
      expired_o <= 1'b1;
    end
  end
endmodule : mps_nocomm_timer

// *** mps_pkg.sv ***
// Contract
// - Diode channel measured from power-up
// - Main rail sense measured from power-up
// - Quiet start counter gated by rail on
// - Battery input measured before setup complete
// - Battery below low limit disables intrusion
// - Shared fan drives float high at power-up
// - Dedicated fan drive off after power-up
// - No bus traffic 4.6 s: full speed (code: only before the first bus cycle since reset)
// - Other channels wait for setup complete
// - Configuration 3 bit 6 enables XOR tree
// - XOR of inputs on open-drain pin
package mps_pkg;
  localparam logic [7:0] MPS_CFG1_ADDR = 8'h01;
  localparam logic [7:0] MPS_CFG3_ADDR = 8'h03;
  localparam logic [7:0] MPS_BATT_LIMIT_ADDR = 8'h10;
  localparam logic [7:0] MPS_BATT_MEAS_ADDR = 8'h11;
  localparam logic [7:0] MPS_FAN_DUTY_ADDR = 8'h12;
  localparam logic [7:0] MPS_STATUS_ADDR = 8'h13;
  localparam int MPS_ADDR_W = 8;
  localparam int MPS_SETUP_BIT = 5;
  localparam int MPS_XOR_BIT = 6;
  localparam logic [7:0] MPS_CFG1_RESET = 8'h81;
  localparam logic [7:0] MPS_CFG3_RESET = 8'h00;
  localparam logic [7:0] MPS_BATT_LIMIT_RESET = 8'h80;
  localparam logic [7:0] MPS_FAN_DUTY_RESET = 8'h00;
  localparam logic [7:0] MPS_FULL_DUTY = 8'hFF;
  localparam longint MPS_CLK_HZ = 50000000;
  localparam longint MPS_NOCOMM_MS = 4600;
  localparam longint MPS_NOCOMM_CYCLES = (MPS_NOCOMM_MS * MPS_CLK_HZ) / 1000;
  typedef enum logic [1:0] {MPS_RAIL_OFF, MPS_WAITING, MPS_FULL, MPS_PROGRAMMED} mps_fan_state_t;
endpackage : mps_pkg

// *** mps_sequencer.sv ***
`timescale 1ns/1ns
module mps_sequencer
  import mps_pkg::*;
#(
  parameter int unsigned NOCOMM_COUNT = 32'(MPS_NOCOMM_CYCLES),
  parameter int XOR_PINS = 8,
  parameter int OTHER_CHANNELS = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [MPS_ADDR_W-1:0] adr_i,
  input wire logic [7:0] dat_i,
  input wire logic sel_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  input wire logic main_rail_on_i,
  input wire logic [7:0] battery_sample_i,
  input wire logic battery_sample_valid_i,
  input wire logic [XOR_PINS-1:0] xor_pins_i,
  output logic diode_meas_en_o,
  output logic main_rail_sense_en_o,
  output logic battery_meas_en_o,
  output logic [OTHER_CHANNELS-1:0] channel_meas_en_o,
  output logic chassis_intrusion_en_o,
  output logic quiet_start_run_o,
  output logic [2:0] shared_fan_drive_oe_o,
  output logic [2:0] shared_fan_drive_o,
  output logic [7:0] dedicated_fan_drive_duty_o,
  output logic dedicated_full_speed_o,
  output logic xor_tree_out_o,
  output logic xor_tree_out_oe_o,
  output logic xor_mode_o
);
  logic [7:0] cfg1;
  logic [7:0] cfg3;
  logic [7:0] batt_limit;
  logic [7:0] batt_meas;
  logic [7:0] fan_duty;
  logic ack_q;
  logic bus_seen;
  logic expired;
  logic xor_bit;
  mps_fan_state_t fan_state;
  mps_fan_state_t next_fan_state;

  wire req = cyc_i && stb_i && !ack_q;
  wire wr = req && we_i && sel_i;
  wire hit_cfg1 = (adr_i == MPS_CFG1_ADDR);
  wire hit_cfg3 = (adr_i == MPS_CFG3_ADDR);
  wire hit_lim = (adr_i == MPS_BATT_LIMIT_ADDR);
  wire hit_duty = (adr_i == MPS_FAN_DUTY_ADDR);
  wire setup_done = cfg1[MPS_SETUP_BIT];
  wire batt_low = (batt_meas < batt_limit);
  wire [7:0] status_word = {4'h0, batt_low, expired, main_rail_on_i, setup_done};
  wire [7:0] read_word = hit_cfg1 ? cfg1 :
                         hit_cfg3 ? cfg3 :
                         hit_lim ? batt_limit :
                         (adr_i == MPS_BATT_MEAS_ADDR) ? batt_meas :
                         hit_duty ? fan_duty :
                         (adr_i == MPS_STATUS_ADDR) ? status_word : 8'h00;

  // Any accepted bus cycle counts as communication
  assign bus_seen = req;

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= 8'h00;
    end else begin
      ack_q <= req;
      dat_o <= req ? read_word : dat_o;
    end
  end
  assign ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg1 <= MPS_CFG1_RESET;
      cfg3 <= MPS_CFG3_RESET;
      batt_limit <= MPS_BATT_LIMIT_RESET;
      fan_duty <= MPS_FAN_DUTY_RESET;
    end else if (wr) begin
      if (hit_cfg1) cfg1 <= dat_i;
      if (hit_cfg3) cfg3 <= dat_i;
      if (hit_lim) batt_limit <= dat_i;
      if (hit_duty) fan_duty <= dat_i;
    end
  end

  // Battery reading starts high so intrusion stays on until first sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      batt_meas <= MPS_FULL_DUTY;
    end else if (battery_sample_valid_i) begin
      batt_meas <= battery_sample_i;
    end
  end

  assign diode_meas_en_o = 1'b1;
  assign main_rail_sense_en_o = 1'b1;
  assign battery_meas_en_o = 1'b1;
  assign channel_meas_en_o = {OTHER_CHANNELS{setup_done}};
  assign chassis_intrusion_en_o = !batt_low;
  assign quiet_start_run_o = main_rail_on_i;

  // Shared pins released so pull-ups drive fans full on
  assign shared_fan_drive_oe_o = 3'b000;
  assign shared_fan_drive_o = 3'b000;

  mps_nocomm_timer #(
    .COUNT(NOCOMM_COUNT)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rail_on_i(main_rail_on_i),
    .bus_seen_i(bus_seen),
    .expired_o(expired)
  );

  // Once programmed, later silence never forces full speed again
  always_comb begin
    next_fan_state = fan_state;
    unique case (fan_state)
      MPS_RAIL_OFF: if (bus_seen) next_fan_state = MPS_PROGRAMMED;
                    else if (main_rail_on_i) next_fan_state = MPS_WAITING;
      MPS_WAITING: if (bus_seen) next_fan_state = MPS_PROGRAMMED;
                   else if (!main_rail_on_i) next_fan_state = MPS_RAIL_OFF;
                   else if (expired) next_fan_state = MPS_FULL;
      MPS_FULL: if (bus_seen) next_fan_state = MPS_PROGRAMMED;
                else if (!main_rail_on_i) next_fan_state = MPS_RAIL_OFF;
      MPS_PROGRAMMED: next_fan_state = MPS_PROGRAMMED;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) fan_state <= MPS_RAIL_OFF;
    else fan_state <= next_fan_state;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dedicated_fan_drive_duty_o <= MPS_FAN_DUTY_RESET;
    end else begin
      unique case (next_fan_state)
        MPS_FULL: dedicated_fan_drive_duty_o <= MPS_FULL_DUTY;
        MPS_PROGRAMMED: dedicated_fan_drive_duty_o <= fan_duty;
        default: dedicated_fan_drive_duty_o <= MPS_FAN_DUTY_RESET;
      endcase
    end
  end
  assign dedicated_full_speed_o = (fan_state == MPS_FULL);

  assign xor_bit = cfg3[MPS_XOR_BIT];
  assign xor_mode_o = xor_bit;

  mps_xor_tree #(
    .N(XOR_PINS)
  ) u_xor (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(xor_bit),
    .pins_i(xor_pins_i),
    .xor_o(xor_tree_out_o)
  );
  // Open drain: drive only when pulling low
  assign xor_tree_out_oe_o = xor_bit && !xor_tree_out_o;

  a_meas_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_meas_en_o == {OTHER_CHANNELS{cfg1[MPS_SETUP_BIT]}})
    else $error("channel enables disagree with setup bit");
  a_early_on: assert property (@(posedge clk_i) disable iff (rst_i)
    diode_meas_en_o && main_rail_sense_en_o && battery_meas_en_o)
    else $error("early channel not measured");
  a_rail_sense: assert property (@(posedge clk_i) disable iff (rst_i)
    main_rail_sense_en_o)
    else $error("rail sense not measured");
  a_batt_meas: assert property (@(posedge clk_i) disable iff (rst_i)
    battery_meas_en_o)
    else $error("battery input not measured");
  a_ci_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (batt_meas < batt_limit) |-> !chassis_intrusion_en_o)
    else $error("intrusion on with low battery");
  a_quiet_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet_start_run_o |-> main_rail_on_i)
    else $error("quiet start runs with rail off");
  a_shared_float: assert property (@(posedge clk_i) disable iff (rst_i)
    shared_fan_drive_oe_o == 3'b000)
    else $error("shared fan pin driven");
  a_ded_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (fan_state == MPS_RAIL_OFF) |=> (dedicated_fan_drive_duty_o == MPS_FAN_DUTY_RESET)
      || (fan_state != MPS_RAIL_OFF))
    else $error("dedicated drive not off");
  a_full_speed: assert property (@(posedge clk_i) disable iff (rst_i)
    (fan_state == MPS_WAITING && expired && main_rail_on_i && !bus_seen) |=> ##1
      (dedicated_fan_drive_duty_o == MPS_FULL_DUTY) || fan_state != MPS_FULL)
    else $error("no full speed after silence");
  a_full_duty: assert property (@(posedge clk_i) disable iff (rst_i)
    dedicated_full_speed_o |-> (dedicated_fan_drive_duty_o == MPS_FULL_DUTY))
    else $error("full speed state without full duty");
  a_prog_duty: assert property (@(posedge clk_i) disable iff (rst_i)
    (fan_state == MPS_PROGRAMMED) |=> (dedicated_fan_drive_duty_o == $past(fan_duty)))
    else $error("dedicated drive ignores programmed duty");
  a_xor_out: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg3[MPS_XOR_BIT] && $stable(cfg3) |=> (xor_tree_out_o == ^$past(xor_pins_i)))
    else $error("xor output wrong");
  a_xor_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    xor_tree_out_oe_o |-> (xor_mode_o && !xor_tree_out_o))
    else $error("xor pin driven high or outside test mode");
  a_timer_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !main_rail_on_i |=> !expired)
    else $error("timer not cleared with rail off");
  a_xor_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_cfg3) |=> (xor_mode_o == $past(dat_i[MPS_XOR_BIT])))
    else $error("xor mode not from cfg3 write");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  c_setup: cover property (@(posedge clk_i) disable iff (rst_i) $rose(setup_done));
  c_full: cover property (@(posedge clk_i) disable iff (rst_i) fan_state == MPS_FULL);
  c_prog: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fan_state == MPS_PROGRAMMED));
  c_xor: cover property (@(posedge clk_i) disable iff (rst_i) xor_tree_out_oe_o);
endmodule : mps_sequencer

// *** mps_xor_tree.sv ***
`timescale 1ns/1ns
module mps_xor_tree
  import mps_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [N-1:0] pins_i,
  output logic xor_o
);
  wire [N-1:0] chain;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chain
      if (g == 0) begin : g_first
        assign chain[g] = pins_i[g];
      end else begin : g_rest
        assign chain[g] = chain[g-1] ^ pins_i[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xor_o <= 1'b1;
    end else begin
      xor_o <= enable_i ? chain[N-1] : 1'b1;
    end
  end
endmodule : mps_xor_tree

// *** tb_monitor_powerup_sequencer.sv ***
`timescale 1ns/1ns
module tb_monitor_powerup_sequencer
  import mps_pkg::*;
;
`define CK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
  logic clk_i = 0;
  logic rst_i = 1;
  logic rail = 0;
  logic bvalid = 0;
  logic [7:0] bsample = 8'h00;
  logic [7:0] pins = 8'h00;
  logic [7:0] q, adr, wdat, rdat, duty;
  logic cyc, stb, we, sel, ack, diode, rsense, batt, intr, quiet, full, xo, xoe, xmode;
  logic [9:0] chan;
  logic [2:0] sh_oe, sh_d;
  int mismatches = 0;
  int checked = 0;
  always #10 clk_i = ~clk_i;
  // Short watchdog count keeps the run brief
  mps_sequencer #(.NOCOMM_COUNT(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .main_rail_on_i(rail), .battery_sample_i(bsample), .battery_sample_valid_i(bvalid),
    .xor_pins_i(pins), .diode_meas_en_o(diode), .main_rail_sense_en_o(rsense),
    .battery_meas_en_o(batt), .channel_meas_en_o(chan), .chassis_intrusion_en_o(intr),
    .quiet_start_run_o(quiet), .shared_fan_drive_oe_o(sh_oe), .shared_fan_drive_o(sh_d),
    .dedicated_fan_drive_duty_o(duty), .dedicated_full_speed_o(full), .xor_tree_out_o(xo),
    .xor_tree_out_oe_o(xoe), .xor_mode_o(xmode));
  mps_host_model host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .wdat_o(wdat), .sel_o(sel));
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic hang();
    mismatches++;
    report_and_stop();
  endtask : hang
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic t_powerup();
    `CK(diode, 1'b1)
    `CK(rsense, 1'b1)
    `CK(batt, 1'b1)
    `CK(chan, 10'h000)
    `CK(sh_oe, 3'h0)
    `CK(sh_d, 3'h0)
    `CK(duty, MPS_FAN_DUTY_RESET)
    `CK(quiet, 1'b0)
  endtask : t_powerup
  task automatic t_watchdog();
    int n;
    @(posedge clk_i);
    rail <= 1'b1;
    settle(1);
    `CK(quiet, 1'b1)
    settle(10);
    @(posedge clk_i);
    rail <= 1'b0;
    settle(2);
    `CK(quiet, 1'b0)
    @(posedge clk_i);
    rail <= 1'b1;
    settle(15);
    `CK(duty, 8'h00)
    n = 0;
    while (full !== 1'b1 && n < 30) begin
      settle(1);
      n++;
    end
    if (n >= 30) hang();
    settle(2);
    `CK(duty, MPS_FULL_DUTY)
    host.xfer(1'b1, MPS_FAN_DUTY_ADDR, 8'h40, q);
    settle(2);
    `CK({full, duty}, 9'h040)
  endtask : t_watchdog
  task automatic t_regs();
    host.xfer(1'b0, MPS_CFG1_ADDR, 8'h00, q);
    `CK(q, MPS_CFG1_RESET)
    host.xfer(1'b0, MPS_BATT_LIMIT_ADDR, 8'h00, q);
    `CK(q, MPS_BATT_LIMIT_RESET)
    host.xfer(1'b0, 8'h55, 8'h00, q);
    `CK(q, 8'h00)
  endtask : t_regs
  task automatic load_batt(input logic [7:0] v);
    @(posedge clk_i);
    bsample <= v;
    bvalid <= 1'b1;
    @(posedge clk_i);
    bvalid <= 1'b0;
    settle(1);
  endtask : load_batt
  task automatic t_battery();
    load_batt(8'h7F);
    `CK(intr, 1'b0)
    load_batt(8'h80);
    `CK(intr, 1'b1)
    host.xfer(1'b0, MPS_BATT_MEAS_ADDR, 8'h00, q);
    `CK(q, 8'h80)
  endtask : t_battery
  task automatic t_setup();
    `CK(chan, 10'h000)
    host.configure(MPS_BATT_LIMIT_RESET, 8'h40);
    `CK(chan, 10'h3FF)
    `CK(diode & rsense & batt, 1'b1)
  endtask : t_setup
  task automatic t_xor();
    @(posedge clk_i);
    pins <= 8'hA5;
    settle(2);
    `CK(xo, 1'b1)
    host.xfer(1'b1, MPS_CFG3_ADDR, 8'h40, q);
    `CK(xmode, 1'b1)
    settle(2);
    `CK({xo, xoe}, 2'h1)
    @(posedge clk_i);
    pins <= 8'hA4;
    settle(2);
    `CK({xo, xoe}, 2'h2)
  endtask : t_xor
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    t_powerup();
    t_watchdog();
    t_regs();
    t_battery();
    t_setup();
    t_xor();
    report_and_stop();
  end
endmodule : tb_monitor_powerup_sequencer
